// ---- hdl/uart_pins_regs.svh ----
`ifndef UART_PINS_REGS_SVH
`define UART_PINS_REGS_SVH

// Timing of the bit clock derived from the 25 MHz system clock.
`define CLK_HZ 25000000
`define BAUD_HZ 115200
`define OVERSAMPLE 16
`define BAUD_DIV_CYCLES (`CLK_HZ / (`BAUD_HZ * `OVERSAMPLE))

// Sample points within one bit time, counted in oversample ticks, and the index of the last data bit.
`define SAMPLE_MID 4'h7
`define SAMPLE_LAST 4'hf
`define LAST_DATA_BIT 3'h7

// Pin levels after reset and when the port is not using the line.
`define MARK_LEVEL 1'b1
`define RTS_INACTIVE 1'b1

// Transmit buffer shape.
`define TX_FIFO_WIDTH 8
`define TX_FIFO_DEPTH 16

`endif

// ---- hdl/uart_pins_pkg.sv ----
package uart_pins_pkg;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_STOP  = 4'h8
  } tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_t;

  // Software-side control of one port.
  typedef struct packed {
    logic loopback;
    logic rts_request;
  } port_ctl_t;

  // One received character with its framing verdict.
  typedef struct packed {
    logic frame_err;
    logic [7:0] data;
  } rx_byte_t;

endpackage

// ---- hdl/byte_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [CW-1:0] ZERO_COUNT = '0;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic in_ready_r;
  logic out_valid_r;

  // Handshakes qualify every pointer move.
  wire push = in_valid & in_ready_r;
  wire pop = out_valid_r & out_ready;

  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = mem[rd_ptr_r];

  // Depth must be a power of two so the pointers wrap by themselves.
  always_comb begin
    count_nxt = count_r + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
  end

  // Flags are registered from the next count, so they are never stale.
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_nxt;
      in_ready_r <= (count_nxt != FULL_COUNT);
      out_valid_r <= (count_nxt != ZERO_COUNT);
    end
  end

  // Storage carries no reset; only the pointers and the count decide what is valid.
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr_r] <= in_data;
  end

endmodule

`default_nettype wire

// ---- hdl/dual_uart_modem_pins.sv ----
// Operation
// - Two independent ports, fast and console, each with own data and handshake.
// - Reset drives each serial output to mark, logic 1, until sending.
// - Each port captures its clear-to-send level as readable status.
// - Port drives request-to-send low to announce it is ready.
// - Reset forces request-to-send to inactive logic 1.
// - Loopback holds request-to-send at logic 1 regardless of software.
`include "uart_pins_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module dual_uart_modem_pins
  import uart_pins_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic fast_port_serial_in,
  output logic fast_port_serial_out,
  input wire logic fast_port_clear_to_send_n,
  output logic fast_port_request_to_send_n,
  input wire logic [7:0] fast_tx_data,
  input wire logic fast_tx_valid,
  output logic fast_tx_ready,
  output logic [7:0] fast_rx_data,
  output logic fast_rx_valid,
  output logic fast_rx_frame_err,
  input wire port_ctl_t fast_ctl,
  output logic fast_cts_status,
  input wire logic console_port_serial_in,
  output logic console_port_serial_out,
  input wire logic console_port_clear_to_send_n,
  output logic console_port_request_to_send_n,
  input wire logic [7:0] console_tx_data,
  input wire logic console_tx_valid,
  output logic console_tx_ready,
  output logic [7:0] console_rx_data,
  output logic console_rx_valid,
  output logic console_rx_frame_err,
  input wire port_ctl_t console_ctl,
  output logic console_cts_status
);

  localparam logic [7:0] DIV_LAST = 8'(`BAUD_DIV_CYCLES - 1);

  // Index 0 is the fast port, index 1 the console port.
  wire [1:0] pin_in = {console_port_serial_in, fast_port_serial_in};
  wire [1:0] cts_n_in = {console_port_clear_to_send_n,
                         fast_port_clear_to_send_n};
  wire [7:0] tx_data_in [2];
  wire [1:0] tx_valid_in = {console_tx_valid, fast_tx_valid};
  wire port_ctl_t ctl_in [2];
  assign tx_data_in[0] = fast_tx_data;
  assign tx_data_in[1] = console_tx_data;
  assign ctl_in[0] = fast_ctl;
  assign ctl_in[1] = console_ctl;

  logic [1:0] pin_out_r;
  logic [1:0] rts_n_r;
  logic [1:0] cts_status_r;
  logic [1:0] rx_valid_r;
  logic [1:0] fifo_ready;
  rx_byte_t rx_byte_r [2];

  // One shared divider makes the oversample tick for both ports; they
  // therefore run at the same rate, which keeps the divider count down.
  logic [7:0] div_r;
  logic tick_r;
  wire div_wrap = (div_r == DIV_LAST);

  always_ff @(posedge clk) begin
    if (srst) begin
      div_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_wrap ? 8'h00 : div_r + 8'h01;
      tick_r <= div_wrap;
    end
  end

  // Fast port and console port are the same logic, built twice.
  for (genvar p = 0; p < 2; p++) begin : g_port
    tx_state_t tx_state_r;
    rx_state_t rx_state_r;
    logic [7:0] tx_shift_r;
    logic [2:0] tx_bit_r;
    logic [3:0] tx_phase_r;
    logic tx_line_r;
    logic [7:0] rx_shift_r;
    logic [2:0] rx_bit_r;
    logic [3:0] rx_phase_r;
    logic [7:0] fifo_data;
    logic fifo_valid;

    // Loopback stands in for the modem's consent, so a looped port can
    // send even when nothing is attached to the handshake pin.
    wire tx_allowed = ctl_in[p].loopback | ~cts_n_in[p];
    wire tx_take = (tx_state_r == TX_IDLE) & tx_allowed;
    wire tx_bit_end = tick_r & (tx_phase_r == `SAMPLE_LAST);
    wire rx_line = ctl_in[p].loopback ? tx_line_r : pin_in[p];
    wire rx_mid = tick_r & (rx_phase_r == `SAMPLE_MID);
    wire rx_end = tick_r & (rx_phase_r == `SAMPLE_LAST);

    byte_fifo #(
      .WIDTH(`TX_FIFO_WIDTH),
      .DEPTH(`TX_FIFO_DEPTH)
    ) u_tx_fifo (
      .clk(clk),
      .srst(srst),
      .in_data(tx_data_in[p]),
      .in_valid(tx_valid_in[p]),
      .in_ready(fifo_ready[p]),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(tx_take)
    );

    // Transmitter: start bit, eight data bits LSB first, one stop bit.
    always_ff @(posedge clk) begin
      if (srst) begin
        tx_state_r <= TX_IDLE;
        tx_line_r <= `MARK_LEVEL;
        tx_shift_r <= 8'h00;
        tx_bit_r <= 3'h0;
        tx_phase_r <= 4'h0;
      end else begin
        if (tick_r) tx_phase_r <= tx_phase_r + 4'h1;
        unique case (tx_state_r)
          TX_IDLE: begin
            if (fifo_valid & tx_allowed) begin
              tx_shift_r <= fifo_data;
              tx_line_r <= 1'b0;
              tx_phase_r <= 4'h0;
              tx_state_r <= TX_START;
            end
          end
          TX_START: begin
            if (tx_bit_end) begin
              tx_line_r <= tx_shift_r[0];
              tx_bit_r <= 3'h0;
              tx_state_r <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (tx_bit_end) begin
              if (tx_bit_r == `LAST_DATA_BIT) begin
                tx_line_r <= `MARK_LEVEL;
                tx_state_r <= TX_STOP;
              end else begin
                tx_line_r <= tx_shift_r[1];
                tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                tx_bit_r <= tx_bit_r + 3'h1;
              end
            end
          end
          TX_STOP: begin
            if (tx_bit_end) tx_state_r <= TX_IDLE;
          end
        endcase
      end
    end

    // Receiver: a start bit must still be low at mid-bit, else it is noise.
    always_ff @(posedge clk) begin
      if (srst) begin
        rx_state_r <= RX_IDLE;
        rx_shift_r <= 8'h00;
        rx_bit_r <= 3'h0;
        rx_phase_r <= 4'h0;
        rx_valid_r[p] <= 1'b0;
        rx_byte_r[p] <= '0;
      end else begin
        rx_valid_r[p] <= 1'b0;
        if (tick_r) rx_phase_r <= rx_phase_r + 4'h1;
        unique case (rx_state_r)
          RX_IDLE: begin
            if (tick_r & ~rx_line) begin
              rx_phase_r <= 4'h1;
              rx_state_r <= RX_START;
            end
          end
          RX_START: begin
            if (rx_mid) begin
              rx_phase_r <= 4'h0;
              rx_bit_r <= 3'h0;
              rx_state_r <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_end) begin
              rx_shift_r <= {rx_line, rx_shift_r[7:1]};
              rx_bit_r <= rx_bit_r + 3'h1;
              if (rx_bit_r == `LAST_DATA_BIT) rx_state_r <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_end) begin
              rx_byte_r[p].data <= rx_shift_r;
              rx_byte_r[p].frame_err <= ~rx_line;
              rx_valid_r[p] <= 1'b1;
              rx_state_r <= RX_IDLE;
            end
          end
        endcase
      end
    end

    // Pin drivers and status are registered so the pins never glitch.
    always_ff @(posedge clk) begin
      if (srst) begin
        pin_out_r[p] <= `MARK_LEVEL;
        rts_n_r[p] <= `RTS_INACTIVE;
        cts_status_r[p] <= 1'b0;
      end else begin
        pin_out_r[p] <= ctl_in[p].loopback ? `MARK_LEVEL : tx_line_r;
        rts_n_r[p] <= ctl_in[p].loopback ? `RTS_INACTIVE
                                         : ~ctl_in[p].rts_request;
        cts_status_r[p] <= ~cts_n_in[p];
      end
    end
  end

  // Top-level outputs are the registered per-port values.
  assign fast_port_serial_out = pin_out_r[0];
  assign fast_port_request_to_send_n = rts_n_r[0];
  assign fast_cts_status = cts_status_r[0];
  assign fast_tx_ready = fifo_ready[0];
  assign fast_rx_data = rx_byte_r[0].data;
  assign fast_rx_frame_err = rx_byte_r[0].frame_err;
  assign fast_rx_valid = rx_valid_r[0];
  assign console_port_serial_out = pin_out_r[1];
  assign console_port_request_to_send_n = rts_n_r[1];
  assign console_cts_status = cts_status_r[1];
  assign console_tx_ready = fifo_ready[1];
  assign console_rx_data = rx_byte_r[1].data;
  assign console_rx_frame_err = rx_byte_r[1].frame_err;
  assign console_rx_valid = rx_valid_r[1];

endmodule

`default_nettype wire

// ---- testbench/uart_pins_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module uart_pins_checker
  import uart_pins_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic fast_port_serial_out,
  input wire logic fast_port_clear_to_send_n,
  input wire logic fast_port_request_to_send_n,
  input wire port_ctl_t fast_ctl,
  input wire logic fast_cts_status,
  input wire logic fast_rx_valid,
  input wire logic console_port_serial_out,
  input wire logic console_port_clear_to_send_n,
  input wire logic console_port_request_to_send_n,
  input wire port_ctl_t console_ctl,
  input wire logic console_cts_status,
  input wire logic console_rx_valid
);
  // Reset values are judged at the first edge after release.
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_reset_mark:
  assert property ($past(srst) |->
    fast_port_serial_out && console_port_serial_out)
    else $error("serial out not at mark after reset");
  a_reset_rts:
  assert property ($past(srst) |->
    fast_port_request_to_send_n && console_port_request_to_send_n)
    else $error("request-to-send active after reset");
  a_fast_cts:
  assert property (!$past(srst) |->
    fast_cts_status == !$past(fast_port_clear_to_send_n))
    else $error("fast clear-to-send status wrong");
  a_con_cts:
  assert property (!$past(srst) |->
    console_cts_status == !$past(console_port_clear_to_send_n))
    else $error("console clear-to-send status wrong");
  a_fast_rts:
  assert property (!$past(srst) |-> fast_port_request_to_send_n ==
    ($past(fast_ctl.loopback) || !$past(fast_ctl.rts_request)))
    else $error("fast request-to-send wrong");
  a_con_rts:
  assert property (!$past(srst) |-> console_port_request_to_send_n ==
    ($past(console_ctl.loopback) || !$past(console_ctl.rts_request)))
    else $error("console request-to-send wrong");
  a_fast_loop_mark:
  assert property (fast_ctl.loopback [*2] |-> fast_port_serial_out)
    else $error("fast pin left mark in loopback");
  a_con_loop_mark:
  assert property (console_ctl.loopback [*2] |-> console_port_serial_out)
    else $error("console pin left mark in loopback");

  // Received bytes on both ports and loopback with request-to-send asked, each seen at least once.
  c_fast_rx: cover property (fast_rx_valid);
  c_con_rx: cover property (console_rx_valid);
  c_loop_req: cover property (fast_ctl.loopback && fast_ctl.rts_request);
endmodule
`default_nettype wire

// ---- testbench/modem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module modem_model (
  input wire logic clk,
  input wire logic [1:0] busy,
  input wire logic cable_in,
  output logic [1:0] cts_n,
  output logic line_out,
  output logic cable_out
);
  // Clear-to-send is low only while the modem can take data.
  assign cts_n = busy;
  // A null-modem lead carries the fast port's line to the console input.
  assign cable_out = cable_in;
  // The line rests at its pulled-up mark between frames.
  initial line_out = 1'b1;

  // One frame, LSB first, 208 clocks a bit to match the port's rate.
  // A low stop bit forces a framing error; the line returns to mark after.
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (208) @(posedge clk);
      #1;
    end
    line_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import uart_pins_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic f_in, f_out, f_rts_n, f_rdy, f_rv, f_fe, f_cs;
  logic c_in, c_out, c_rts_n, c_rdy, c_rv, c_fe, c_cs;
  logic [1:0] cts_n;
  logic [1:0] busy = 2'b11;
  logic [7:0] f_rd, c_rd, b;
  logic [7:0] f_td = 8'h00;
  logic f_tv = 1'b0;
  logic [7:0] c_td = 8'h00;
  logic c_tv = 1'b0;
  port_ctl_t f_ctl = 2'h0;
  port_ctl_t c_ctl = 2'h0;
  int miscompares = 0;
  int cmp_count = 0;
  int seed = 99;
  int n;
  logic [7:0] q[$];

  // Free-running clock, 40 ns period.
  always #20 clk = ~clk;

  dual_uart_modem_pins i_dut (
    .clk(clk), .srst(srst),
    .fast_port_serial_in(f_in), .fast_port_serial_out(f_out),
    .fast_port_clear_to_send_n(cts_n[0]),
    .fast_port_request_to_send_n(f_rts_n),
    .fast_tx_data(f_td), .fast_tx_valid(f_tv), .fast_tx_ready(f_rdy),
    .fast_rx_data(f_rd), .fast_rx_valid(f_rv), .fast_rx_frame_err(f_fe),
    .fast_ctl(f_ctl), .fast_cts_status(f_cs),
    .console_port_serial_in(c_in), .console_port_serial_out(c_out),
    .console_port_clear_to_send_n(cts_n[1]),
    .console_port_request_to_send_n(c_rts_n),
    .console_tx_data(c_td), .console_tx_valid(c_tv),
    .console_tx_ready(c_rdy), .console_rx_data(c_rd),
    .console_rx_valid(c_rv), .console_rx_frame_err(c_fe),
    .console_ctl(c_ctl), .console_cts_status(c_cs)
  );
  modem_model i_modem (
    .clk(clk), .busy(busy), .cable_in(f_out), .cts_n(cts_n),
    .line_out(f_in), .cable_out(c_in)
  );

  // Helpers: comparison, verdict, stepping past an edge.
  task automatic chk(input string nm, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  function automatic logic rts_exp(input port_ctl_t c);
    return c.loopback | ~c.rts_request;
  endfunction

  // Reset is held four edges; pins must already be idle by then.
  task automatic do_reset();
    srst = 1'b1;
    tick(4);
    chk("f_tx_idle", f_out, 8'h01);
    chk("c_tx_idle", c_out, 8'h01);
    chk("f_rts_off", f_rts_n, 8'h01);
    chk("c_rts_off", c_rts_n, 8'h01);
    srst = 1'b0;
    tick(1);
  endtask

  // Valid stays high afterwards so bytes can follow back to back.
  task automatic put(input logic con, input logic [7:0] d);
    int k;
    if (con) begin
      c_td = d;
      c_tv = 1'b1;
    end else begin
      f_td = d;
      f_tv = 1'b1;
    end
    for (k = 0; k < 4000 && (con ? c_rdy : f_rdy) !== 1'b1; k++) tick(1);
    if (k == 4000) begin
      miscompares++;
      final_report();
    end
    tick(1);
  endtask

  // Waits for a byte; with pin set, that port's serial pin must stay at mark.
  task automatic wait_rx(input logic con, input logic pin);
    int k;
    for (k = 0; k < 4000; k++) begin
      if ((con ? c_rv : f_rv) === 1'b1) break;
      if (pin) chk("pin", con ? c_out : f_out, 8'h01);
      tick(1);
    end
    if (k == 4000) begin
      miscompares++;
      final_report();
    end
  endtask

  initial begin
    do_reset();
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      {f_ctl, c_ctl, busy} = 6'($random(seed));
      tick(2);
      chk("f_rts", f_rts_n, rts_exp(f_ctl));
      chk("c_rts", c_rts_n, rts_exp(c_ctl));
      chk("f_cts", f_cs, !busy[0]);
      chk("c_cts", c_cs, !busy[1]);
    end
    f_ctl = 2'h1;
    c_ctl = 2'h1;
    tick(2);
    do_reset();
    $display("handshake test done");
    f_ctl = 2'h0;
    busy = 2'b00;
    b = 8'($random(seed));
    fork
      i_modem.send(b, 1'b1);
      wait_rx(1'b0, 1'b0);
    join
    chk("f_rx", f_rd, b);
    chk("f_fe", f_fe, 8'h00);
    // A low stop bit still delivers the byte but flags it. The low line
    // that follows can look like a start bit, so a reset clears the port.
    b = 8'($random(seed));
    fork
      i_modem.send(b, 1'b0);
      wait_rx(1'b0, 1'b0);
    join
    chk("f_rx_bad", f_rd, b);
    chk("f_fe_bad", f_fe, 8'h01);
    do_reset();
    $display("modem test done");
    // Loopback must send even with the modem not ready, on both ports.
    f_ctl = 2'h2;
    c_ctl = 2'h2;
    busy = 2'b11;
    tick(2);
    b = 8'($random(seed));
    put(1'b0, b);
    f_tv = 1'b0;
    wait_rx(1'b0, 1'b1);
    chk("loop", f_rd, b);
    b = 8'($random(seed));
    put(1'b1, b);
    c_tv = 1'b0;
    wait_rx(1'b1, 1'b1);
    chk("c_loop", c_rd, b);
    tick(300);
    $display("loopback test done");
    // Fill while the modem stalls, then drain to the console port.
    f_ctl = 2'h0;
    c_ctl = 2'h1;
    tick(2);
    for (n = 0; n < 20 && f_rdy === 1'b1; n++) begin
      b = 8'($random(seed));
      q.push_back(b);
      put(1'b0, b);
    end
    f_tv = 1'b0;
    chk("fill", 8'(n), 8'h10);
    tick(300);
    chk("gated", f_out, 8'h01);
    busy = 2'b00;
    repeat (16) begin
      wait_rx(1'b1, 1'b0);
      chk("drain", c_rd, q.pop_front());
      chk("c_fe", c_fe, 8'h00);
      tick(1);
    end
    chk("empty", f_rdy, 8'h01);
    chk("c_empty", c_rdy, 8'h01);
    $display("fifo test done");
    final_report();
  end
endmodule
bind dual_uart_modem_pins uart_pins_checker i_chk (
  .clk(clk),
  .srst(srst),
  .fast_port_serial_out(fast_port_serial_out),
  .fast_port_clear_to_send_n(fast_port_clear_to_send_n),
  .fast_port_request_to_send_n(fast_port_request_to_send_n),
  .fast_ctl(fast_ctl),
  .fast_cts_status(fast_cts_status),
  .fast_rx_valid(fast_rx_valid),
  .console_port_serial_out(console_port_serial_out),
  .console_port_clear_to_send_n(console_port_clear_to_send_n),
  .console_port_request_to_send_n(console_port_request_to_send_n),
  .console_ctl(console_ctl),
  .console_cts_status(console_cts_status),
  .console_rx_valid(console_rx_valid)
);
`default_nettype wire
